// ===== rtl/dhp_host_port.sv
// 8080-style host port, picture memory and frame scan of a 240x400 display
// assumes host strobe phases last at least three clocks; all pins but reset_n are asynchronous
`timescale 1ns/1ps
module dhp_host_port #(
  parameter int OSC_DIV = 16,
  parameter logic [15:0] DEVICE_ID = 16'h5a5a // arbitrary value
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic chipSelectN,
  input wire logic register_select,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [17:0] dataIn,
  output logic [17:0] dataOut,
  output logic dataOe,
  input wire logic width_strap_0,
  input wire logic width_strap_1,
  input wire logic vsyncModeEnable,
  input wire logic vsyncN,
  output logic frame_marker_out,
  output logic [17:0] scanPixel,
  output logic scanValid
);
  localparam int DW = $clog2(OSC_DIV + 1);
  localparam int AW = dhp_pkg::GRAM_AW;

  if (OSC_DIV * dhp_pkg::CLKS_PER_LINE < dhp_pkg::H_PIXELS + 2) begin : g_chk_div
    $error("dhp_host_port: a line is too short to fetch one pixel row");
  end
  if (dhp_pkg::GRAM_DEPTH * dhp_pkg::PIXEL_BITS / 8 > dhp_pkg::GRAM_BYTES) begin : g_chk_ram
    $error("dhp_host_port: picture exceeds memory");
  end

  function automatic logic [17:0] expand565(input logic [15:0] w, input logic d);
    expand565 = {w[15:11], d, w[10:5], w[4:0], d};
  endfunction

  function automatic logic [15:0] word16(input logic [17:0] d);
    word16 = {d[17:10], d[8:1]};
  endfunction

  function automatic logic isNarrow(input dhp_pkg::dhp_width_t w);
    isNarrow = (w == dhp_pkg::DHP_W9) || (w == dhp_pkg::DHP_W8);
  endfunction

  // pin synchronisers; only the second stage is read
  logic [dhp_pkg::SYNC_W-1:0] syncA, syncB;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      syncA <= '1;
      syncB <= '1;
    end else begin
      syncA <= {chipSelectN, register_select, readStrobeN, writeStrobeN, width_strap_0, width_strap_1,
                vsyncModeEnable, vsyncN, dataIn};
      syncB <= syncA;
    end
  end
  logic csN, rs, rdN, wrN, vsMode, vsN;
  logic [17:0] dIn;
  assign {csN, rs, rdN, wrN} = syncB[25:22];
  assign {vsMode, vsN} = syncB[19:18];
  assign dIn = syncB[17:0];

  logic rdNPrev, wrNPrev, vsNPrev;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdNPrev <= 1'b1;
      wrNPrev <= 1'b1;
      vsNPrev <= 1'b1;
    end else begin
      rdNPrev <= rdN;
      wrNPrev <= wrN;
      vsNPrev <= vsN;
    end
  end
  logic wrDone, rdStart, rdDone, vsFall;
  assign wrDone = !csN && wrN && !wrNPrev;
  assign rdStart = !csN && !rdN && rdNPrev;
  assign rdDone = !csN && rdN && !rdNPrev;
  assign vsFall = vsMode && !vsN && vsNPrev;

  // straps are caught once, after the synchronisers have filled
  dhp_pkg::dhp_width_t width;
  logic [1:0] settleCnt;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      width <= dhp_pkg::DEFAULT_WIDTH;
      settleCnt <= 2'h0;
    end else if (settleCnt != dhp_pkg::STRAP_SETTLE) begin
      settleCnt <= settleCnt + 2'h1;
      if (settleCnt == dhp_pkg::STRAP_SETTLE - 2'h1) begin
        width <= dhp_pkg::dhp_width_t'(syncB[21:20]);
      end
    end
  end

  // write assembly: narrow modes pair two transfers, upper part first
  logic wrHalf;
  logic [8:0] wrHi;
  logic [15:0] index;
  logic [7:0] haddr;
  logic [8:0] vaddr;
  logic [15:0] w16;
  logic [17:0] pixIn;
  logic ditherBit, wrWord, gramWrite, rdHalf, gramAdvance;
  logic [AW-1:0] pixAddr;
  assign ditherBit = haddr[0] ^ vaddr[0];
  assign pixAddr = AW'(32'(vaddr) * dhp_pkg::H_PIXELS + 32'(haddr));
  assign wrWord = wrDone && !(isNarrow(width) && !wrHalf);

  always_comb begin
    w16 = isNarrow(width) ? {wrHi[8:1], dIn[17:10]} : word16(dIn);
    case (width)
      dhp_pkg::DHP_W18: pixIn = dIn;
      dhp_pkg::DHP_W9: pixIn = {wrHi, dIn[17:9]};
      default: pixIn = expand565(w16, ditherBit);
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrHalf <= 1'b0;
      wrHi <= 9'h000;
    end else if (wrDone) begin
      wrHalf <= isNarrow(width) && !wrHalf;
      wrHi <= dIn[17:9];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      index <= dhp_pkg::INDEX_RESET;
    end else if (wrWord && !rs) begin
      index <= w16;
    end
  end

  assign gramWrite = wrWord && rs && index == dhp_pkg::IDX_GRAM;
  assign gramAdvance = gramWrite || (rdDone && rs && index == dhp_pkg::IDX_GRAM && !(isNarrow(width) && !rdHalf));

  // address counter steps through the picture and wraps at its end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      haddr <= 8'h00;
      vaddr <= 9'h000;
    end else if (wrWord && rs && index == dhp_pkg::IDX_HADDR) begin
      haddr <= w16[7:0];
    end else if (wrWord && rs && index == dhp_pkg::IDX_VADDR) begin
      vaddr <= w16[8:0];
    end else if (gramAdvance) begin
      if (haddr == 8'(dhp_pkg::H_PIXELS - 1)) begin
        haddr <= 8'h00;
        vaddr <= (vaddr == 9'(dhp_pkg::V_LINES - 1)) ? 9'h000 : vaddr + 9'h001;
      end else begin
        haddr <= haddr + 8'h01;
      end
    end
  end

  // read path: data are formed when the strobe falls and held until the next read strobe falls
  logic [17:0] hostRd, scanRd, rdWord;
  logic [15:0] src16;
  always_comb begin
    src16 = (index == dhp_pkg::IDX_GRAM) ? {hostRd[17:13], hostRd[11:6], hostRd[5:1]} : DEVICE_ID;
    case (width)
      dhp_pkg::DHP_W18: rdWord = (index == dhp_pkg::IDX_GRAM) ? hostRd : {src16[15:8], 1'b0, src16[7:0], 1'b0};
      dhp_pkg::DHP_W16: rdWord = {src16[15:8], 1'b0, src16[7:0], 1'b0};
      dhp_pkg::DHP_W9: begin
        if (index == dhp_pkg::IDX_GRAM) begin
          rdWord = rdHalf ? {hostRd[8:0], 9'h000} : {hostRd[17:9], 9'h000};
        end else begin
          rdWord = rdHalf ? {src16[7:0], 10'h000} : {src16[15:8], 10'h000};
        end
      end
      default: rdWord = rdHalf ? {src16[7:0], 10'h000} : {src16[15:8], 10'h000};
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dataOut <= 18'h00000;
      dataOe <= 1'b0;
      rdHalf <= 1'b0;
    end else begin
      dataOe <= !csN && !rdN;
      if (rdStart) begin
        dataOut <= (rs && (index == dhp_pkg::IDX_GRAM || index == dhp_pkg::IDX_ID)) ? rdWord : 18'h00000;
      end
      if (rdDone) begin
        rdHalf <= isNarrow(width) && !rdHalf;
      end
    end
  end

  // frame scan; a tick of the divider stands in for the internal oscillator
  dhp_pkg::dhp_scan_t scanState;
  logic [DW-1:0] divCnt;
  logic [3:0] lineClk;
  logic [8:0] lineCnt;
  logic [7:0] col;
  logic colBusy, colBusyD, oscTick, lineEnd, frameEnd, restart, colStart;
  logic [8:0] dispLine;
  logic [AW-1:0] scanAddr;
  assign oscTick = divCnt == DW'(OSC_DIV - 1);
  assign lineEnd = oscTick && lineClk == 4'(dhp_pkg::CLKS_PER_LINE - 1);
  assign frameEnd = lineEnd && lineCnt == 9'(dhp_pkg::TOTAL_LINES - 1);
  assign restart = vsFall;
  assign dispLine = lineCnt - 9'(dhp_pkg::BACK_PORCH);
  assign scanAddr = AW'(32'(dispLine) * dhp_pkg::H_PIXELS + 32'(col));
  assign colStart = scanState == dhp_pkg::SCAN_RUN && divCnt == '0 && lineClk == 4'h0
                    && lineCnt >= 9'(dhp_pkg::BACK_PORCH)
                    && lineCnt < 9'(dhp_pkg::BACK_PORCH + dhp_pkg::V_LINES);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scanState <= dhp_pkg::SCAN_RUN;
      divCnt <= '0;
      lineClk <= 4'h0;
      lineCnt <= 9'h000;
    end else if (restart) begin
      scanState <= dhp_pkg::SCAN_RUN;
      divCnt <= '0;
      lineClk <= 4'h0;
      lineCnt <= 9'h000;
    end else begin
      case (scanState)
        dhp_pkg::SCAN_RUN: begin
          divCnt <= oscTick ? '0 : divCnt + DW'(1);
          if (oscTick) begin
            lineClk <= lineClk + 4'h1;
          end
          if (frameEnd) begin
            lineCnt <= 9'h000;
            if (vsMode) begin
              scanState <= dhp_pkg::SCAN_WAIT;
            end
          end else if (lineEnd) begin
            lineCnt <= lineCnt + 9'h001;
          end
        end
        dhp_pkg::SCAN_WAIT: begin
          if (!vsMode) begin
            scanState <= dhp_pkg::SCAN_RUN;
          end
        end
        default: scanState <= dhp_pkg::SCAN_RUN;
      endcase
    end
  end

  // frame head is marked at the wrap in free run and at each accepted sync
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      frame_marker_out <= 1'b0;
    end else begin
      frame_marker_out <= restart || (scanState == dhp_pkg::SCAN_RUN && frameEnd && !vsMode);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      col <= 8'h00;
      colBusy <= 1'b0;
      colBusyD <= 1'b0;
      scanValid <= 1'b0;
      scanPixel <= 18'h00000;
    end else begin
      colBusyD <= colBusy;
      scanValid <= colBusyD; // memory read and output register add two stages behind col
      scanPixel <= scanRd;
      if (colStart) begin
        colBusy <= 1'b1;
        col <= 8'h00;
      end else if (colBusy) begin
        colBusy <= col != 8'(dhp_pkg::H_PIXELS - 1);
        col <= col + 8'h01;
      end
    end
  end

  dhp_gram #(
    .DEPTH(dhp_pkg::GRAM_DEPTH),
    .WIDTH(dhp_pkg::PIXEL_BITS),
    .AW(AW)
  ) u_gram (
    .clock(clock),
    .wrEn(gramWrite),
    .wrAddr(pixAddr),
    .wrData(pixIn),
    .rdAddrA(pixAddr),
    .rdDataA(hostRd),
    .rdAddrB(scanAddr),
    .rdDataB(scanRd)
  );
endmodule

// ===== rtl/dhp_pkg.sv
// constants and types shared by the display host port and its picture memory
// assumes nothing of its surroundings; imported by nobody, used by scoped name
package dhp_pkg;
  localparam int H_PIXELS = 240;
  localparam int V_LINES = 400;
  localparam int GRAM_BYTES = 233280;
  localparam int PIXEL_BITS = 18;
  localparam int CLKS_PER_LINE = 16;
  localparam int FRONT_PORCH = 8;
  localparam int BACK_PORCH = 8;
  localparam int TOTAL_LINES = V_LINES + FRONT_PORCH + BACK_PORCH;
  localparam int GRAM_DEPTH = H_PIXELS * V_LINES;
  localparam int GRAM_AW = 17;
  localparam int SYNC_W = 26;
  // encoding is {width_strap_0, width_strap_1}
  typedef enum logic [1:0] {
    DHP_W18 = 2'h0,
    DHP_W9 = 2'h1,
    DHP_W16 = 2'h2,
    DHP_W8 = 2'h3
  } dhp_width_t;
  localparam dhp_width_t DEFAULT_WIDTH = DHP_W8;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [15:0] IDX_ID = 16'h0000;
  localparam logic [15:0] IDX_HADDR = 16'h0200;
  localparam logic [15:0] IDX_VADDR = 16'h0201;
  localparam logic [15:0] IDX_GRAM = 16'h0202;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SCAN_WAIT = 2'h1,
    SCAN_RUN = 2'h2
  } dhp_scan_t;
endpackage

// ===== rtl/dhp_gram.sv
// picture memory: one write port, two registered read ports
// assumes addresses stay below DEPTH
`timescale 1ns/1ps
module dhp_gram #(
  parameter int DEPTH = dhp_pkg::GRAM_DEPTH,
  parameter int WIDTH = dhp_pkg::PIXEL_BITS,
  parameter int AW = dhp_pkg::GRAM_AW
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddrA,
  output logic [WIDTH-1:0] rdDataA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [WIDTH-1:0] rdDataB
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("dhp_gram: DEPTH does not fit AW");
  end

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end
endmodule

// ===== dv/dhp_host_port_properties.sv
// timing checks on the display host port pins
// assumes host strobe and sync phases of at least four clocks
`timescale 1ns/1ps
module dhp_host_port_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic [17:0] dataOut,
  input wire logic dataOe,
  input wire logic vsyncModeEnable,
  input wire logic vsyncN,
  input wire logic frame_marker_out,
  input wire logic scanValid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [8:0] runLen;
  always_ff @(posedge clock) begin
    if (!reset_n) runLen <= 9'h000;
    else runLen <= scanValid ? runLen + 9'h001 : 9'h000;
  end
  a_oe_needs_read: assert property (dataOe |-> $past(!chipSelectN && !readStrobeN, 3))
    else $error("data lines driven outside a read");
  a_oe_follows_read: assert property ((!chipSelectN && !readStrobeN) [*4] |-> dataOe)
    else $error("read strobe not answered");
  a_oe_off_deselect: assert property (chipSelectN [*4] |-> !dataOe)
    else $error("data lines driven while deselected");
  a_dout_held: assert property (readStrobeN [*4] |-> $stable(dataOut))
    else $error("read data changed between reads");
  a_marker_pulse: assert property (frame_marker_out |=> !frame_marker_out)
    else $error("frame marker longer than one cycle");
  a_marker_on_sync: assert property (vsyncModeEnable && $fell(vsyncN) |-> ##[2:5] frame_marker_out)
    else $error("no frame marker after vertical sync");
  a_marker_needs_sync: assert property (frame_marker_out && vsyncModeEnable |-> $past(!vsyncN, 3))
    else $error("frame marker without vertical sync");
  a_line_length: assert property ($fell(scanValid) |-> runLen == 9'd240)
    else $error("active line not 240 pixels");
  a_line_gap: assert property ($fell(scanValid) |-> !scanValid [*8])
    else $error("line blanking too short");
  c_marker: cover property (frame_marker_out);
  c_read: cover property ($rose(dataOe));
  c_line: cover property ($fell(scanValid));
endmodule
bind dhp_host_port dhp_host_port_properties u_props (.clock(clock), .reset_n(reset_n),
  .chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .dataOut(dataOut), .dataOe(dataOe),
  .vsyncModeEnable(vsyncModeEnable), .vsyncN(vsyncN), .frame_marker_out(frame_marker_out),
  .scanValid(scanValid));

// ===== dv/dhp_host_model.sv
// host processor on the 8080-style bus, one transfer per call
// assumes a free-running clock; drives the inverted previous value on the data lines while reading
`timescale 1ns/1ps
module dhp_host_model (
  input wire logic clock,
  input wire logic [17:0] dataOut,
  output logic chipSelectN,
  output logic register_select,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic [17:0] dataIn
);
  initial begin
    chipSelectN = 1'b1;
    register_select = 1'b0;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    dataIn = 18'h00000;
  end
  // phases of four clocks keep clear of the two-stage pin synchronisers
  task automatic xfer(input logic rs, input logic rd, input logic [17:0] d, output logic [17:0] q);
    @(posedge clock);
    #1;
    chipSelectN = 1'b0;
    register_select = rs;
    dataIn = rd ? ~dataIn : d;
    if (rd) readStrobeN = 1'b0;
    else writeStrobeN = 1'b0;
    repeat (4) @(posedge clock);
    q = dataOut;
    #1;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chipSelectN = 1'b1;
    dataIn = ~dataIn;
  endtask
endmodule

// ===== dv/dhp_host_port_tb.sv
// bench for the display host port: widths, picture memory, vertical sync
// assumes the host model drives the bus; straps change only under reset
`timescale 1ns/1ps
module dhp_host_port_tb;
  localparam logic [15:0] ID = 16'h3c96; // arbitrary value
  localparam logic [17:0] PIX = 18'h2a5c3;
  localparam logic [17:0] PIX2 = 18'h15a3c;
  localparam logic [15:0] C565 = 16'hb6d3;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic s0 = 1'b1;
  logic s1 = 1'b1;
  logic vsyncModeEnable = 1'b0;
  logic vsyncN = 1'b1;
  logic chipSelectN, register_select, readStrobeN, writeStrobeN, dataOe, frame_marker_out, scanValid;
  logic [17:0] dataIn, dataOut, scanPixel, q;
  logic [15:0] v;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  dhp_pkg::dhp_width_t mode;
  always #2 clock = ~clock;
  dhp_host_port #(.DEVICE_ID(ID)) DUT (.clock(clock), .reset_n(reset_n), .chipSelectN(chipSelectN),
    .register_select(register_select), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .width_strap_0(s0), .width_strap_1(s1),
    .vsyncModeEnable(vsyncModeEnable), .vsyncN(vsyncN), .frame_marker_out(frame_marker_out),
    .scanPixel(scanPixel), .scanValid(scanValid));
  dhp_host_model HOST (.clock(clock), .dataOut(dataOut), .chipSelectN(chipSelectN),
    .register_select(register_select), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .dataIn(dataIn));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic restart(input logic [1:0] st);
    @(posedge clock);
    #1;
    reset_n = 1'b0;
    {s0, s1} = st;
    mode = dhp_pkg::dhp_width_t'(st);
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // narrow widths move register values as two bytes on the top lines
  task automatic put16(input logic rs, input logic [15:0] d);
    if (mode == dhp_pkg::DHP_W8 || mode == dhp_pkg::DHP_W9) begin
      HOST.xfer(rs, 1'b0, {d[15:8], 10'h000}, q);
      HOST.xfer(rs, 1'b0, {d[7:0], 10'h000}, q);
    end else HOST.xfer(rs, 1'b0, {d[15:8], 1'b0, d[7:0], 1'b0}, q);
  endtask
  task automatic get16(output logic [15:0] d);
    logic [17:0] h;
    if (mode == dhp_pkg::DHP_W8 || mode == dhp_pkg::DHP_W9) begin
      HOST.xfer(1'b1, 1'b1, 18'h00000, h);
      HOST.xfer(1'b1, 1'b1, 18'h00000, q);
      d = {h[17:10], q[17:10]};
    end else begin
      HOST.xfer(1'b1, 1'b1, 18'h00000, q);
      d = {q[17:10], q[8:1]};
    end
  endtask
  // a 5-6-5 pixel written in 8-bit mode, read back in 8-bit and then whole in 18-bit mode
  task automatic t_pixel565();
    restart(2'h3);
    for (int i = 0; i < 2; i++) begin
      put16(1'b0, dhp_pkg::IDX_HADDR);
      put16(1'b1, 16'h0005);
      put16(1'b0, dhp_pkg::IDX_GRAM);
      if (i == 0) put16(1'b1, C565);
    end
    get16(v);
    chk({2'h0, v}, {2'h0, C565});
    restart(2'h0);
    put16(1'b0, dhp_pkg::IDX_HADDR);
    put16(1'b1, 16'h0005);
    put16(1'b0, dhp_pkg::IDX_GRAM);
    HOST.xfer(1'b1, 1'b1, 18'h00000, q);
    // odd column on line 0: both red and blue fill bits are one
    chk(q, {C565[15:11], 1'b1, C565[10:5], C565[4:0], 1'b1});
  endtask
  // delivered strap setting first, then each rework
  task automatic t_widths();
    logic [1:0] straps [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      restart(straps[i]);
      put16(1'b0, dhp_pkg::IDX_ID);
      get16(v);
      chk({2'h0, v}, {2'h0, ID});
    end
  endtask
  task automatic t_pixel();
    put16(1'b0, dhp_pkg::IDX_HADDR);
    put16(1'b1, 16'h0000);
    put16(1'b0, dhp_pkg::IDX_VADDR);
    put16(1'b1, 16'h0000);
    put16(1'b0, dhp_pkg::IDX_GRAM);
    HOST.xfer(1'b1, 1'b0, PIX, q);
    put16(1'b0, dhp_pkg::IDX_HADDR);
    put16(1'b1, 16'h0000);
    put16(1'b0, dhp_pkg::IDX_GRAM);
    HOST.xfer(1'b1, 1'b1, 18'h00000, q);
    chk(q, PIX);
    put16(1'b0, 16'h0001);
    get16(v);
    chk({2'h0, v}, 18'h00000);
  endtask
  // the first active line follows eight porch lines of sixteen ticks
  task automatic t_vsync();
    @(posedge clock);
    #1;
    vsyncModeEnable = 1'b1;
    // only the moving area is refreshed: the pixel after the one already stored
    put16(1'b0, dhp_pkg::IDX_GRAM);
    HOST.xfer(1'b1, 1'b0, PIX2, q);
    repeat (4) @(posedge clock);
    #1;
    vsyncN = 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!frame_marker_out && n < 10);
    chk(18'(n >= 2 && n <= 5), 18'h00001);
    if (n >= 10) conclude();
    vsyncN = 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!scanValid && n < 3000);
    chk(18'(n >= 2048 && n <= 2052), 18'h00001);
    if (n >= 3000) conclude();
    chk(scanPixel, PIX);
    @(posedge clock);
    #1;
    chk(scanPixel, PIX2);
  endtask
  initial begin
    t_pixel565();
    t_widths();
    t_pixel();
    t_vsync();
    repeat (300) @(posedge clock);
    conclude();
  end
endmodule
